// File: adc_cfg_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the per-input configuration register bank
// ----------------------------------------------------------------------------
package adc_cfg_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0] CTRL_IDX = 10'h020;
    localparam logic [9:0] STAT_IDX = 10'h021;
    localparam logic [9:0] CFG_BASE_IDX = 10'h030;
    localparam logic [9:0] THR_BASE_IDX = 10'h040;

    // Sizes
    localparam int NUM_INPUTS = 8;
    localparam int THR_W = 12;
    localparam int RES_W = 19;

    // Configuration register layout and reset
    localparam int HIZ_BIT = 3;
    localparam int OSR_MSB = 1;
    localparam logic [7:0] CFG_RESET = 8'h08;
    localparam logic [7:0] CFG_WMASK = 8'hFB;
    localparam logic [7:0] HIZ_ALL_RESET = 8'hFF;

    // Threshold register reset value
    localparam logic [11:0] THR_RESET = 12'h7FF;

    // Control register: bit 0 selects the advanced sequencer
    localparam int CTRL_ADV_BIT = 0;

    // Result width at a ratio of one; each ratio step adds one bit
    localparam logic [4:0] WIDTH_BASE = 5'h10;

    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

    // Result width for an oversampling code
    function automatic logic [4:0] osr_width(input logic [1:0] oversample_ratio);
        return WIDTH_BASE + {3'h0, oversample_ratio};
    endfunction

    // Upper twelve bits of a right-aligned result whose width follows the code
    function automatic logic [11:0] top12(input logic [18:0] res, input logic [1:0] oversample_ratio);
        logic [11:0] t;
        t = res[15:4];
        case (oversample_ratio)
            2'h0: t = res[15:4];
            2'h1: t = res[16:5];
            2'h2: t = res[17:6];
            2'h3: t = res[18:7];
            default: t = res[15:4];
        endcase
        return t;
    endfunction

endpackage

// File: adc_channel_config_regs.sv
`timescale 1ns/1ps
module adc_channel_config_regs
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Conversion about to start
    input wire logic [2:0] conv_channel_i,
    // Finished conversion
    input wire logic result_valid_i,
    input wire logic [2:0] result_channel_i,
    input wire logic [adc_cfg_pkg::RES_W-1:0] result_i,
    // Settings applied to the front end
    output logic [7:0] hiz_enable_o,
    output logic [1:0] osr_o,
    output logic [4:0] result_width_o,
    // Upper limit check
    output logic above_upper_o,
    output logic above_valid_o
);
    import adc_cfg_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        bus_state_t bus;
        logic [7:0][7:0] cfg;
        logic [7:0][11:0] thr;
        logic adv;
        logic [7:0] above_flags;
        logic [31:0] dat;
        logic [7:0] hiz;
        logic [1:0] oversample_ratio;
        logic [4:0] width;
        logic above;
        logic above_valid;
    } state_t;

    state_t r;
    state_t n;
    logic [9:0] idx;
    logic [7:0] res_cfg;
    logic [1:0] res_osr;
    logic cmp_above;
    logic [7:0] hiz_col;
    logic [1:0] osr_own;
    logic [2:0] thr_ch;

    assign idx = adr_i[11:2];
    assign thr_ch = idx[3:1];

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Configuration in force for an input; the standard sequencer has a
    // single set of controls, so every input follows the first register
    function automatic logic [7:0] eff_cfg(input logic [7:0][7:0] cfg, input logic adv,
                                           input logic [2:0] ch);
        return adv ? cfg[ch] : cfg[0];
    endfunction

    function automatic logic is_cfg(input logic [9:0] a);
        return a[9:3] == CFG_BASE_IDX[9:3];
    endfunction

    // Odd indices between the limits are holes and read as zero
    function automatic logic is_thr(input logic [9:0] a);
        return (a[9:4] == THR_BASE_IDX[9:4]) && (a[0] == 1'b0);
    endfunction

    function automatic logic [31:0] read_word(input state_t s, input logic [9:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (is_cfg(a))
        begin
            w = {24'h00_0000, s.cfg[a[2:0]] & CFG_WMASK};
        end
        else if (is_thr(a))
        begin
            w = {20'h0_0000, s.thr[a[3:1]]};
        end
        else if (a == CTRL_IDX)
        begin
            w = {31'h0000_0000, s.adv};
        end
        else if (a == STAT_IDX)
        begin
            w = {24'h00_0000, s.above_flags};
        end
        return w;
    endfunction

    // ------------------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------------------
    upper_threshold_cmp u_cmp (
        .result_i(result_i),
        .osr_i(res_osr),
        .threshold_i(r.thr[result_channel_i]),
        .above_o(cmp_above)
    );

    // Ratio code of the arriving result, kept apart from the next-state process
    // so the comparator does not feed back into the process that drives it;
    // the rest are observation helpers for the checks below
    always_comb
    begin
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            hiz_col[i] = r.cfg[i][HIZ_BIT];
        end
        osr_own = r.cfg[conv_channel_i][OSR_MSB:0];
        res_cfg = eff_cfg(r.cfg, r.adv, result_channel_i);
        res_osr = res_cfg[OSR_MSB:0];
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] c;
        c = 8'h00;
        n = r;

        // Bus: data is fetched on the request edge, so ack can return next cycle
        case (r.bus)
            BUS_IDLE:
            begin
                if (cyc_i && stb_i)
                begin
                    n.bus = BUS_ACK;
                    n.dat = read_word(r, idx);
                end
            end
            BUS_ACK:
            begin
                n.bus = BUS_IDLE;
                // Writes land on the edge that samples ack
                if (cyc_i && stb_i && we_i)
                begin
                    if (is_cfg(idx) && sel_i[0])
                    begin
                        n.cfg[idx[2:0]] = dat_i[7:0] & CFG_WMASK;
                    end
                    else if (is_thr(idx))
                    begin
                        if (sel_i[0])
                        begin
                            n.thr[idx[3:1]][7:0] = dat_i[7:0];
                        end
                        if (sel_i[1])
                        begin
                            n.thr[idx[3:1]][11:8] = dat_i[11:8];
                        end
                    end
                    else if ((idx == CTRL_IDX) && sel_i[0])
                    begin
                        n.adv = dat_i[CTRL_ADV_BIT];
                    end
                end
            end
            default:
            begin
                n.bus = BUS_IDLE;
            end
        endcase

        // Front-end settings, one cycle behind the registers
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            c = eff_cfg(r.cfg, r.adv, 3'(i));
            n.hiz[i] = c[HIZ_BIT];
        end
        c = eff_cfg(r.cfg, r.adv, conv_channel_i);
        n.oversample_ratio = c[OSR_MSB:0];
        n.width = osr_width(c[OSR_MSB:0]);

        // Limit check; the status word keeps the latest verdict per input
        n.above_valid = result_valid_i;
        if (result_valid_i)
        begin
            n.above = cmp_above;
            n.above_flags[result_channel_i] = cmp_above;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            r.cfg <= {NUM_INPUTS{CFG_RESET}};
            r.thr <= {NUM_INPUTS{THR_RESET}};
            r.hiz <= HIZ_ALL_RESET;
            r.width <= WIDTH_BASE;
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs straight from the state flops
    assign dat_o = r.dat;
    assign ack_o = (r.bus == BUS_ACK);
    assign hiz_enable_o = r.hiz;
    assign osr_o = r.oversample_ratio;
    assign result_width_o = r.width;
    assign above_upper_o = r.above;
    assign above_valid_o = r.above_valid;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence s_ack_once;
        ack_o ##1 !ack_o;
    endsequence

    sequence s_thr_write;
        cyc_i && stb_i && we_i && ack_o && is_thr(idx) && (sel_i[1:0] == 2'h3);
    endsequence

    sequence s_cfg_write;
        cyc_i && stb_i && we_i && ack_o && is_cfg(idx) && sel_i[0];
    endsequence

    property p_ack_pulse;
        s_req |=> s_ack_once;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single cycle after request");

    property p_std_hiz;
        !r.adv |=> (hiz_enable_o == {8{$past(r.cfg[0][HIZ_BIT])}});
    endproperty
    a_std_hiz: assert property (p_std_hiz)
        else $error("standard mode high-Z not taken from first input");

    property p_adv_hiz;
        r.adv |=> (hiz_enable_o == $past(hiz_col));
    endproperty
    a_adv_hiz: assert property (p_adv_hiz)
        else $error("advanced mode high-Z not per input");

    property p_reset_vals;
        disable iff (1'b0)
        rst_i |=> (hiz_enable_o == 8'hFF) && (r.cfg[0] == 8'h08) && (r.thr[7] == 12'h7FF);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong reset values");

    property p_std_osr;
        !r.adv |=> (osr_o == $past(r.cfg[0][OSR_MSB:0]));
    endproperty
    a_std_osr: assert property (p_std_osr)
        else $error("standard mode ratio not from first input");

    property p_adv_osr;
        r.adv |=> (osr_o == $past(osr_own));
    endproperty
    a_adv_osr: assert property (p_adv_osr)
        else $error("advanced mode ratio not from own input");

    property p_width;
        (osr_o == 2'h3) |-> (result_width_o == 5'h13);
    endproperty
    a_width: assert property (p_width)
        else $error("ratio 64 width not 19 bits");

    property p_width_all;
        result_width_o == (5'h10 + {3'h0, osr_o});
    endproperty
    a_width_all: assert property (p_width_all)
        else $error("result width does not follow ratio code");

    property p_upper_cmp;
        result_valid_i |=> above_valid_o &&
            (above_upper_o == ($past(top12(result_i, res_osr)) > $past(r.thr[result_channel_i])));
    endproperty
    a_upper_cmp: assert property (p_upper_cmp)
        else $error("upper limit verdict wrong");

    property p_thr_write;
        s_thr_write |=> (r.thr[$past(thr_ch)] == $past(dat_i[11:0]));
    endproperty
    a_thr_write: assert property (p_thr_write)
        else $error("upper limit write not stored");

    property p_cfg_write;
        s_cfg_write |=> (r.cfg[$past(idx[2:0])] == ($past(dat_i[7:0]) & 8'hFB));
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write not stored");

    property p_rsv_read;
        (ack_o && !we_i && is_cfg(idx)) |-> (dat_o[31:8] == 24'h00_0000) && !dat_o[2];
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved configuration bits read nonzero");

    property p_verdict_hold;
        !result_valid_i |=> !above_valid_o && $stable(above_upper_o);
    endproperty
    a_verdict_hold: assert property (p_verdict_hold)
        else $error("limit verdict changed without a result");

    property p_thr_rsv_read;
        (ack_o && !we_i && is_thr(idx)) |-> (dat_o[31:12] == 20'h0_0000);
    endproperty
    a_thr_rsv_read: assert property (p_thr_rsv_read)
        else $error("reserved limit bits read nonzero");

endmodule

// File: adc_channel_config_regs_tb_top.sv
`timescale 1ns/1ps
module adc_channel_config_regs_tb_top;
    import adc_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, av, above;
    logic rv = 1'b0;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, s;
    logic [2:0] conv_ch = 3'h0;
    logic [2:0] rch = 3'h0;
    logic [18:0] res = 19'h00000;
    logic [7:0] hiz;
    logic [1:0] oversample_ratio;
    logic [4:0] width;
    logic [7:0] cfg_m [8];
    logic [11:0] thr_m [8];
    logic adv = 1'b0;
    logic [3:0] lanes = 4'hF;
    logic [7:0] flags_m = 8'h00;
    int n_mismatch = 0;
    int total_checks = 0;

    always #12.5 clk_i = ~clk_i;

    host_wb_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    adc_channel_config_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .conv_channel_i(conv_ch), .result_valid_i(rv), .result_channel_i(rch),
        .result_i(res), .hiz_enable_o(hiz), .osr_o(oversample_ratio), .result_width_o(width),
        .above_upper_o(above), .above_valid_o(av));

    // ------------------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Ratio code in force for an input under the current sequencer
    function automatic logic [1:0] eff(input logic [2:0] ch);
        return adv ? cfg_m[ch][1:0] : cfg_m[0][1:0];
    endfunction

    function automatic logic [7:0] exp_hiz();
        logic [7:0] h;
        for (int i = 0; i < 8; i++)
            h[i] = adv ? cfg_m[i][3] : cfg_m[0][3];
        return h;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A bus cycle that never answers counts against the design
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic ok;
        host.xfer(w, a, d, lanes, q, ok);
        if (ok !== 1'b1)
            n_mismatch++;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h00000000, q);
        chk(q, e);
    endtask

    task automatic set_cfg(input int n, input logic [7:0] v);
        logic [31:0] q;
        cfg_m[n] = v & CFG_WMASK;
        xfer(1'b1, 12'h0C0 + 12'(4 * n), {rnd() & 32'hFFFFFF00} | {24'h000000, v}, q);
    endtask

    // Settings are registered, so allow one edge to take and one to show
    task automatic settle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic res_chk(input logic [2:0] ch, input logic [18:0] v);
        logic [1:0] k;
        logic [18:0] t;
        logic e;
        k = eff(ch);
        t = v & ((19'h00001 << (5'h10 + 5'(k))) - 19'h00001);
        @(posedge clk_i);
        rv <= 1'b1;
        rch <= ch;
        res <= t;
        @(posedge clk_i);
        rv <= 1'b0;
        @(negedge clk_i);
        chk(av, 32'h1);
        t = t >> (4 + k);
        e = t[11:0] > thr_m[ch];
        flags_m[ch] = e;
        chk(above, e);
    endtask

    // Random results plus the equal case, which must not count as above
    task automatic run_results();
        logic [31:0] r;
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            res_chk(r[2:0], 19'(rnd()));
            res_chk(r[2:0], {thr_m[r[2:0]], 7'h7F} >> (2'h3 - eff(r[2:0])));
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        s = 32'hD22B03D9;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            cfg_m[i] = CFG_RESET;
            rd_chk(12'h0C0 + 12'(4 * i), 32'h00000008);
            rd_chk(12'h100 + 12'(8 * i), 32'h000007FF);
            rd_chk(12'h104 + 12'(8 * i), 32'h00000000);
        end
        settle();
        chk(hiz, 8'hFF);
        chk(width, 5'h10);
        $display("reset test done");
        set_cfg(0, 8'hFF);
        rd_chk(12'h0C0, 32'h000000FB);
        xfer(1'b1, 12'hFFC, 32'hFFFFFFFF, q);
        rd_chk(12'hFFC, 32'h00000000);
        for (int i = 0; i < 8; i++)
        begin
            q = rnd();
            thr_m[i] = q[11:0];
            xfer(1'b1, 12'h100 + 12'(8 * i), q, q);
            rd_chk(12'h100 + 12'(8 * i), {20'h00000, thr_m[i]});
        end
        // Low lane only: limit bits 11:8 must keep their value
        lanes = 4'h1;
        xfer(1'b1, 12'h100, 32'hFFFFF0A5, q);
        lanes = 4'hF;
        thr_m[0][7:0] = 8'hA5;
        rd_chk(12'h100, {20'h00000, thr_m[0]});
        $display("register test done");
        // Standard sequencer: other inputs' settings must not leak through
        for (int c = 0; c < 4; c++)
        begin
            set_cfg(0, (8'(rnd()) & 8'hFC) | 8'(c));
            set_cfg(1 + c, 8'(rnd()));
            conv_ch <= 3'(rnd());
            settle();
            chk(hiz, exp_hiz());
            chk(oversample_ratio, eff(conv_ch));
            chk(width, 5'h10 + 5'(c));
            run_results();
        end
        $display("standard test done");
        xfer(1'b1, 12'h080, 32'h00000001, q);
        adv = 1'b1;
        for (int i = 0; i < 8; i++)
            set_cfg(i, 8'(rnd()));
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            conv_ch <= 3'(i);
            settle();
            chk(oversample_ratio, eff(3'(i)));
            chk(width, 5'h10 + 5'(eff(3'(i))));
        end
        chk(hiz, exp_hiz());
        run_results();
        rd_chk(12'h080, 32'h00000001);
        rd_chk(12'h084, {24'h000000, flags_m});
        $display("advanced test done");
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
endmodule

// File: dummy_end_marker_not_used.sv
`timescale 1ns/1ps

// File: host_wb_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host side of the register bus
// ----------------------------------------------------------------------------
module host_wb_model (
    // Clock
    input wire logic clk_i,
    // Slave answer
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    // Master request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [11:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // Idle bus at time zero
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    // One classic cycle; this host never turns on command conversion modes,
    // so ratio codes it writes need no forced zero
    // Waits as long as the slave needs; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] m, output logic [31:0] q, output logic ok);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= m;
        dat_o <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack_i !== 1'b1);
        q = dat_i;
        ok = ack_i;
        // Released lines show garbage so stale values cannot pass for a request
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= ~w;
        adr_o <= ~a;
        sel_o <= 4'h0;
        dat_o <= ~d;
    endtask
endmodule

// File: upper_threshold_cmp.sv
`timescale 1ns/1ps
module upper_threshold_cmp
    import adc_cfg_pkg::*;
(
    // Conversion result and its ratio code
    input wire logic [adc_cfg_pkg::RES_W-1:0] result_i,
    input wire logic [1:0] osr_i,
    // Limit for this input
    input wire logic [adc_cfg_pkg::THR_W-1:0] threshold_i,
    // Comparison
    output logic above_o
);

    // ------------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------------
    // Only the twelve leading bits take part, so a wider oversampled result
    // does not move the limit
    always_comb
    begin
        above_o = top12(result_i, osr_i) > threshold_i;
    end

endmodule
